/* File: hdl/lssmc_defines.svh */
// Offsets, field positions, reset values and timing counts of the low-side supervisor mode control.
`ifndef LSSMC_DEFINES_SVH
`define LSSMC_DEFINES_SVH

// Register byte addresses on the APB.
`define LSSMC_ADDR_LCTL 8'h00
`define LSSMC_ADDR_HCTL 8'h04
`define LSSMC_ADDR_FLAG 8'h08
`define LSSMC_ADDR_MASK 8'h0c
`define LSSMC_ADDR_LEVEL 8'h10
`define LSSMC_ADDR_STAT 8'h14

// Fields of both supervision control registers.
`define LSSMC_F_SUP_EN 0
`define LSSMC_F_SUP_LPM 1
`define LSSMC_F_SUP_FP 2
`define LSSMC_F_MON_EN 3
`define LSSMC_F_MON_FP 4
`define LSSMC_F_AUTO 5

// Fields of the power unit flag register and of the mask register.
`define LSSMC_F_LSETTLE 0
`define LSSMC_F_HSETTLE 1
`define LSSMC_F_EV_LDONE 2
`define LSSMC_F_EV_HDONE 3
`define LSSMC_F_EV_STUCK 4
`define LSSMC_F_EV_CORE 5
`define LSSMC_EV_MASK 6'h3c

// Reset values.
`define LSSMC_LCTL_RST 6'h01
`define LSSMC_HCTL_RST 6'h00
`define LSSMC_MASK_RST 6'h00
`define LSSMC_LEVEL_RST 2'h0

// Timing: clock rate, times in ns, least times rounded up to whole cycles.
`define LSSMC_CLK_MHZ 250
`define LSSMC_FP_SETTLE_NS 2000
`define LSSMC_NORM_SETTLE_NS 150000
`define LSSMC_HAZARD_NS 1000
`define LSSMC_FP_SETTLE_CYC ((`LSSMC_FP_SETTLE_NS * `LSSMC_CLK_MHZ + 999) / 1000)
`define LSSMC_NORM_SETTLE_CYC ((`LSSMC_NORM_SETTLE_NS * `LSSMC_CLK_MHZ + 999) / 1000)
`define LSSMC_HAZARD_CYC ((`LSSMC_HAZARD_NS * `LSSMC_CLK_MHZ + 999) / 1000)

`endif

/* File: hdl/lssmc_pkg.sv */
// Types and the comparator mode decoder of the low-side supervisor mode control.
package lssmc_pkg;

    // Operating state of one comparator.
    typedef enum logic [1:0] {
        COMP_OFF = 2'h0,
        COMP_NORMAL = 2'h1,
        COMP_FULL = 2'h2
    } lssmc_comp_t;

    // Power mode reported by the core.
    typedef enum logic [2:0] {
        PM_ACTIVE = 3'h0,
        PM_LPM0 = 3'h1,
        PM_LPM1 = 3'h2,
        PM_LPM2 = 3'h3,
        PM_LPM3 = 3'h4,
        PM_LPM4 = 3'h5
    } lssmc_pmode_t;

    // States of the wake hazard tracker.
    typedef enum logic [2:0] {
        HZ_RUN = 3'b001,
        HZ_WINDOW = 3'b010,
        HZ_STUCK = 3'b100
    } lssmc_hz_t;

    // Comparator state from enable, deep-sleep select, performance, auto control and sleep depth.
    function automatic lssmc_comp_t lssmc_comp(input logic en, input logic sel, input logic fp,
                                               input logic auto_ctl, input logic deep);
        lssmc_comp_t st;
        st = COMP_OFF;
        if (!en) begin
            st = COMP_OFF;
        end else if (!deep || (sel && !auto_ctl)) begin
            st = fp ? COMP_FULL : COMP_NORMAL;
        end else if (sel && fp) begin
            st = COMP_NORMAL;
        end else begin
            st = COMP_OFF;
        end
        return st;
    endfunction

endpackage

/* File: hdl/lssmc_settle_timer.sv */
// Down-counter that times one comparator settling delay.
`timescale 1ns/100ps
module lssmc_settle_timer (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire logic [15:0] count_i,
    output logic busy_o,
    output logic done_o
);

    logic [15:0] cnt_q, cnt_d; // Cycles still to run.
    logic busy_q, busy_d; // Delay in progress.
    logic done_q, done_d; // One-cycle pulse at expiry.

    // A new start restarts the delay even while one is running, so the last write always counts.
    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (start_i) begin
            cnt_d = count_i;
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (cnt_q <= 16'h0001) begin
                busy_d = 1'b0;
                done_d = 1'b1;
                cnt_d = 16'h0000;
            end else begin
                cnt_d = cnt_q - 16'h0001;
            end
        end
    end

    // Registers of the timer.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= 16'h0000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy_o = busy_q;
    assign done_o = done_q;

endmodule

/* File: hdl/lssmc_top.sv */
// Low-side supervisor mode control with APB registers, settle timing and wake hazard tracking.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "lssmc_defines.svh"
module lssmc_top import lssmc_pkg::*; #(
    parameter int NORM_SETTLE_CYC = `LSSMC_NORM_SETTLE_CYC
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [2:0] power_mode_i,
    input wire logic wake_irq_i,
    input wire logic core_ok_i,
    output logic [1:0] sup_state_o,
    output logic [1:0] mon_state_o,
    output logic wake_slow_o,
    output logic wake_o,
    output logic stuck_o,
    output logic device_reset_o,
    output logic irq_o
);

    // Settle and hazard counts in cycles; the long one is a parameter so simulation may shorten it.
    localparam logic [15:0] FP_CYC = 16'(`LSSMC_FP_SETTLE_CYC);
    localparam logic [15:0] NORM_CYC = 16'(NORM_SETTLE_CYC);
    localparam logic [15:0] HAZ_CYC = 16'(`LSSMC_HAZARD_CYC);

    // APB answer registers.
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;

    // Software-visible control.
    logic [5:0] lctl_q, lctl_d; // Low side supervision control.
    logic [5:0] hctl_q, hctl_d; // High side supervision control.
    logic [5:0] mask_q, mask_d; // Interrupt mask, same layout as the flag register.
    logic [1:0] level_q, level_d; // Requested core voltage level.
    logic pending_q, pending_d; // A core level raise waits for the low settle delay.

    // Sticky events, hazard tracker and registered outputs.
    logic [5:0] ev_q, ev_d;
    lssmc_hz_t hz_q, hz_d;
    logic [15:0] hz_cnt_q, hz_cnt_d;
    logic armed_q, armed_d; // Hazard configuration captured at deep entry.
    logic deep_prev_q;
    logic [1:0] sup_q, sup_d;
    logic [1:0] mon_q, mon_d;
    logic wslow_q, wslow_d;
    logic wake_q, wake_d;
    logic rst_q, rst_d;
    logic irq_q, irq_d;

    // Synchroniser for the analog core-voltage good indication.
    logic core_meta_q;
    logic core_ok_q;

    // Transfer decode.
    logic commit;
    logic wr;
    logic wr_lctl, wr_hctl, wr_flag, wr_mask, wr_level;
    logic l_start, h_start;
    logic [15:0] l_count, h_count;
    logic l_busy, l_done, h_busy, h_done;
    logic deep;
    logic low_fast, high_hit;
    logic [5:0] flags;

    // Returns one for the word addresses that hold a register.
    function automatic logic addr_ok(input logic [7:0] a);
        return (a == `LSSMC_ADDR_LCTL) || (a == `LSSMC_ADDR_HCTL) || (a == `LSSMC_ADDR_FLAG) ||
               (a == `LSSMC_ADDR_MASK) || (a == `LSSMC_ADDR_LEVEL) || (a == `LSSMC_ADDR_STAT);
    endfunction

    // Settle delay for a control value: short in full performance, long in normal mode.
    function automatic logic [15:0] settle_cyc(input logic [5:0] ctl);
        return ctl[`LSSMC_F_SUP_FP] ? FP_CYC : NORM_CYC;
    endfunction

    // Two flip-flops on the core voltage good pin; only the second is read by logic.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_meta_q <= 1'b0;
            core_ok_q <= 1'b0;
        end else begin
            core_meta_q <= core_ok_i;
            core_ok_q <= core_meta_q;
        end
    end

    // The request is committed at the edge where the master sees pready high.
    assign commit = psel_i & penable_i & pready_q;
    assign wr = commit & pwrite_i;
    assign wr_lctl = wr & (paddr_i == `LSSMC_ADDR_LCTL);
    assign wr_hctl = wr & (paddr_i == `LSSMC_ADDR_HCTL);
    assign wr_flag = wr & (paddr_i == `LSSMC_ADDR_FLAG);
    assign wr_mask = wr & (paddr_i == `LSSMC_ADDR_MASK);
    assign wr_level = wr & (paddr_i == `LSSMC_ADDR_LEVEL);

    // Deep sleep is any of the three lowest power modes.
    assign deep = (power_mode_i == PM_LPM2) || (power_mode_i == PM_LPM3) || (power_mode_i == PM_LPM4);

    // Low side timer restarts on a control write or a level write, using the delay then in force.
    assign l_start = wr_lctl | wr_level;
    assign l_count = wr_lctl ? settle_cyc(pwdata_i[5:0]) : settle_cyc(lctl_q);
    assign h_start = wr_hctl;
    assign h_count = settle_cyc(pwdata_i[5:0]);

    // Low side settle timer; busy is the low settle flag.
    lssmc_settle_timer u_low_timer (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .start_i(l_start),
        .count_i(l_count),
        .busy_o(l_busy),
        .done_o(l_done)
    );

    // High side settle timer; busy is the high settle flag.
    lssmc_settle_timer u_high_timer (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .start_i(h_start),
        .count_i(h_count),
        .busy_o(h_busy),
        .done_o(h_done)
    );

    // Flag register view: live settle flags below the sticky events.
    always_comb begin
        flags = ev_q;
        flags[`LSSMC_F_LSETTLE] = l_busy;
        flags[`LSSMC_F_HSETTLE] = h_busy;
    end

    // APB answer: pready rises one cycle into the access phase, data and error beside it.
    always_comb begin
        pready_d = psel_i & penable_i & ~pready_q;
        pslverr_d = 1'b0;
        prdata_d = 32'h0000_0000;
        if (pready_d) begin
            pslverr_d = ~addr_ok(paddr_i);
            if (!pwrite_i) begin
                unique case (paddr_i)
                    `LSSMC_ADDR_LCTL: prdata_d = {26'h000_0000, lctl_q};
                    `LSSMC_ADDR_HCTL: prdata_d = {26'h000_0000, hctl_q};
                    `LSSMC_ADDR_FLAG: prdata_d = {26'h000_0000, flags};
                    `LSSMC_ADDR_MASK: prdata_d = {26'h000_0000, mask_q};
                    `LSSMC_ADDR_LEVEL: prdata_d = {30'h0000_0000, level_q};
                    `LSSMC_ADDR_STAT: prdata_d = {21'h00_0000, power_mode_i, hz_q, wslow_q, mon_q, sup_q};
                    default: prdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    // APB answer registers.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // Control registers and the pending core level raise.
    always_comb begin
        lctl_d = wr_lctl ? pwdata_i[5:0] : lctl_q;
        hctl_d = wr_hctl ? pwdata_i[5:0] : hctl_q;
        mask_d = wr_mask ? (pwdata_i[5:0] & `LSSMC_EV_MASK) : mask_q;
        level_d = wr_level ? pwdata_i[1:0] : level_q;
        pending_d = pending_q;
        // A raise is judged when the delay now starting expires; software is expected to pick
        // normal mode first so the long delay covers the ramp.
        if (wr_level && (pwdata_i[1:0] > level_q)) begin
            pending_d = 1'b1;
        end else if (wr_lctl || l_done) begin
            pending_d = 1'b0;
        end
    end

    // Control registers.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lctl_q <= `LSSMC_LCTL_RST;
            hctl_q <= `LSSMC_HCTL_RST;
            mask_q <= `LSSMC_MASK_RST;
            level_q <= `LSSMC_LEVEL_RST;
            pending_q <= 1'b0;
        end else begin
            lctl_q <= lctl_d;
            hctl_q <= hctl_d;
            mask_q <= mask_d;
            level_q <= level_d;
            pending_q <= pending_d;
        end
    end

    // Low side counts as fast wake when any comparator is off or in full performance.
    assign low_fast = ~lctl_q[`LSSMC_F_SUP_EN] | lctl_q[`LSSMC_F_SUP_FP] |
                      ~lctl_q[`LSSMC_F_MON_EN] | lctl_q[`LSSMC_F_MON_FP];
    // High side is affected when a normal-mode comparator drops to off on deep entry.
    assign high_hit = (hctl_q[`LSSMC_F_SUP_EN] & ~hctl_q[`LSSMC_F_SUP_FP] &
                       (~hctl_q[`LSSMC_F_SUP_LPM] | hctl_q[`LSSMC_F_AUTO])) |
                      (hctl_q[`LSSMC_F_MON_EN] & ~hctl_q[`LSSMC_F_MON_FP] & hctl_q[`LSSMC_F_AUTO]);

    // Wake hazard tracker: an interrupt inside the window after deep entry, when the entry armed it, leaves the part hung.
    always_comb begin
        hz_d = hz_q;
        hz_cnt_d = hz_cnt_q;
        armed_d = armed_q;
        wake_d = 1'b0;
        unique case (hz_q)
            HZ_RUN: begin
                wake_d = deep & wake_irq_i;
                // Entry from software or the automatic return after a handler look the same here.
                if (deep && !deep_prev_q) begin
                    hz_d = HZ_WINDOW;
                    hz_cnt_d = HAZ_CYC;
                    armed_d = (low_fast & high_hit) | l_busy | h_busy;
                end
            end
            HZ_WINDOW: begin
                if (wake_irq_i && armed_q) begin
                    hz_d = HZ_STUCK;
                end else begin
                    wake_d = deep & wake_irq_i;
                    if (!deep || wake_irq_i || hz_cnt_q <= 16'h0001) begin
                        hz_d = HZ_RUN;
                    end else begin
                        hz_cnt_d = hz_cnt_q - 16'h0001;
                    end
                end
            end
            HZ_STUCK: begin
                // Only the asynchronous reset, fed by pin reset, power cycle or power-up clear, leaves.
                hz_d = HZ_STUCK;
            end
            default: begin
                hz_d = HZ_RUN;
            end
        endcase
    end

    // Hazard tracker registers; reset always returns it to normal running.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hz_q <= HZ_RUN;
            hz_cnt_q <= 16'h0000;
            armed_q <= 1'b0;
            deep_prev_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            hz_q <= hz_d;
            hz_cnt_q <= hz_cnt_d;
            armed_q <= armed_d;
            deep_prev_q <= deep;
            wake_q <= wake_d;
        end
    end

    // Comparator states, wake-up speed, core failure reset, sticky events and interrupt.
    always_comb begin
        sup_d = lssmc_comp(lctl_q[`LSSMC_F_SUP_EN], lctl_q[`LSSMC_F_SUP_LPM], lctl_q[`LSSMC_F_SUP_FP],
                           lctl_q[`LSSMC_F_AUTO], deep);
        // The monitor has no select of its own: it behaves as select one.
        mon_d = lssmc_comp(lctl_q[`LSSMC_F_MON_EN], 1'b1, lctl_q[`LSSMC_F_MON_FP],
                           lctl_q[`LSSMC_F_AUTO], deep);
        wslow_d = (lctl_q[`LSSMC_F_SUP_EN] & ~lctl_q[`LSSMC_F_SUP_FP]) |
                  (lctl_q[`LSSMC_F_MON_EN] & ~lctl_q[`LSSMC_F_MON_FP]);
        // Core not at the new level when the supervisor delay runs out resets the device.
        rst_d = l_done & pending_q & ~core_ok_q;
        // Write one clears an event; a new event in the same cycle wins over the clear.
        ev_d = ev_q & ~(wr_flag ? (pwdata_i[5:0] & `LSSMC_EV_MASK) : 6'h00);
        if (l_done) begin
            ev_d[`LSSMC_F_EV_LDONE] = 1'b1;
        end
        if (h_done) begin
            ev_d[`LSSMC_F_EV_HDONE] = 1'b1;
        end
        if (hz_q == HZ_WINDOW && hz_d == HZ_STUCK) begin
            ev_d[`LSSMC_F_EV_STUCK] = 1'b1;
        end
        if (rst_d) begin
            ev_d[`LSSMC_F_EV_CORE] = 1'b1;
        end
        irq_d = |(ev_d & mask_d);
    end

    // Status and output registers.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sup_q <= COMP_OFF;
            mon_q <= COMP_OFF;
            wslow_q <= 1'b0;
            rst_q <= 1'b0;
            ev_q <= 6'h00;
            irq_q <= 1'b0;
        end else begin
            sup_q <= sup_d;
            mon_q <= mon_d;
            wslow_q <= wslow_d;
            rst_q <= rst_d;
            ev_q <= ev_d;
            irq_q <= irq_d;
        end
    end

    // Every top-level output comes from a flip-flop, except stuck_o, which is decoded from the registered tracker state.
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign sup_state_o = sup_q;
    assign mon_state_o = mon_q;
    assign wake_slow_o = wslow_q;
    assign wake_o = wake_q;
    assign stuck_o = (hz_q == HZ_STUCK);
    assign device_reset_o = rst_q;
    assign irq_o = irq_q;

endmodule

/* File: sim/lssmc_top_chk.sv */
// Port-level assertions of the low-side supervisor mode control.
`timescale 1ns/100ps
`include "lssmc_defines.svh"
module lssmc_top_chk #(
    parameter int NORM_SETTLE_CYC = 40
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [2:0] power_mode_i,
    input wire logic wake_irq_i,
    input wire logic core_ok_i,
    input wire logic [1:0] sup_state_o,
    input wire logic [1:0] mon_state_o,
    input wire logic wake_slow_o,
    input wire logic wake_o,
    input wire logic stuck_o,
    input wire logic device_reset_o,
    input wire logic irq_o
);
    logic [5:0] lctl_q; // Shadow of the low-side control register.
    logic [5:0] lctl_d; // Its next value.
    logic deep; // Core sits in one of the deep sleep modes.
    logic slow_exp; // Deep wake-up should take the slow time.

    // The shadow follows completed writes only, so it lines up with the register.
    always_comb begin
        lctl_d = lctl_q;
        if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == `LSSMC_ADDR_LCTL) begin
            lctl_d = pwdata_i[5:0];
        end
    end

    // Register the shadow; it resets with the block.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lctl_q <= `LSSMC_LCTL_RST;
        end else begin
            lctl_q <= lctl_d;
        end
    end

    assign deep = power_mode_i >= 3'h3;
    assign slow_exp = (lctl_q[0] && !lctl_q[2]) || (lctl_q[3] && !lctl_q[4]);

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    property p_ready_wait;
        psel_i && !penable_i ##1 psel_i && penable_i |=> pready_o;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready missing after one wait");

    property p_err_ready;
        pslverr_o |-> pready_o;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");

    property p_sup_off;
        !lctl_q[0] |=> sup_state_o == 2'h0;
    endproperty
    a_sup_off: assert property (p_sup_off) else $error("disabled supervisor not off");

    property p_sup_deep;
        lctl_q[0] && !lctl_q[1] && deep |=> sup_state_o == 2'h0;
    endproperty
    a_sup_deep: assert property (p_sup_deep) else $error("supervisor on in deep sleep");

    property p_sup_auto;
        lctl_q[0] && lctl_q[1] && lctl_q[5] && deep |=> sup_state_o == {1'b0, $past(lctl_q[2])};
    endproperty
    a_sup_auto: assert property (p_sup_auto) else $error("supervisor not demoted");

    property p_mon_man;
        lctl_q[3] && !lctl_q[5] |=> mon_state_o == ($past(lctl_q[4]) ? 2'h2 : 2'h1);
    endproperty
    a_mon_man: assert property (p_mon_man) else $error("monitor state wrong");

    property p_slow;
        1'b1 |=> wake_slow_o == $past(slow_exp);
    endproperty
    a_slow: assert property (p_slow) else $error("wake-up speed wrong");

    property p_rst_pulse;
        device_reset_o |=> !device_reset_o;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("device reset too long");

    property p_stuck_hold;
        stuck_o |=> stuck_o && !wake_o;
    endproperty
    a_stuck_hold: assert property (p_stuck_hold) else $error("hung device woke");

    property p_wake;
        deep && wake_irq_i && !stuck_o |=> wake_o || stuck_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake request lost");
endmodule

bind lssmc_top lssmc_top_chk #(.NORM_SETTLE_CYC(NORM_SETTLE_CYC)) u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .power_mode_i(power_mode_i),
    .wake_irq_i(wake_irq_i), .core_ok_i(core_ok_i), .sup_state_o(sup_state_o), .mon_state_o(mon_state_o),
    .wake_slow_o(wake_slow_o), .wake_o(wake_o), .stuck_o(stuck_o), .device_reset_o(device_reset_o), .irq_o(irq_o));

/* File: sim/lssmc_top_tb_top.sv */
// Self-checking bench of the low-side supervisor mode control.
`timescale 1ns/100ps
`include "lssmc_defines.svh"
module lssmc_top_tb_top;
    localparam int NORM = 40; // Short normal settle keeps the run brief.
    localparam int FP = `LSSMC_FP_SETTLE_CYC;
    logic mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [2:0] pmode = 3'h0;
    logic irq_in = 1'b0, core_ok = 1'b1, pready, pslverr, wake_slow, wake, stuck, dev_rst, irq, e;
    logic [1:0] sup, mon;
    int err_total = 0, samples_checked = 0, cyc = 0, pulses = 0, t, seed = 7372;

    lssmc_top #(.NORM_SETTLE_CYC(NORM)) uut (.mclk_i(mclk), .reset_n_i(reset_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .power_mode_i(pmode), .wake_irq_i(irq_in), .core_ok_i(core_ok),
        .sup_state_o(sup), .mon_state_o(mon), .wake_slow_o(wake_slow), .wake_o(wake), .stuck_o(stuck),
        .device_reset_o(dev_rst), .irq_o(irq));

    initial forever #2 mclk = ~mclk;

    // Counts reset pulses and cuts a hang short.
    always @(posedge mclk) begin
        cyc++;
        if (dev_rst === 1'b1) pulses++;
        if (cyc == 60000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; the request is held until ready is seen at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        cmp("apb answer", n < 50, 1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
    endtask

    // Software waits until both settle flags are clear before sleeping.
    task automatic wait_settled();
        do begin
            apb(1'b0, `LSSMC_ADDR_FLAG, 32'h0);
        end while (q[1:0] !== 2'b00);
    endtask

    // Deep entry, then a wake request after dly cycles.
    task automatic hz(input int dly, input logic hung);
        pmode <= 3'h3 + 3'(unsigned'($random(seed)) % 3);
        repeat (dly) @(posedge mclk);
        irq_in <= 1'b1;
        repeat (2) @(posedge mclk);
        cmp("stuck", stuck, hung);
        cmp("wake", wake, !hung);
        irq_in <= 1'b0;
        pmode <= 3'h0;
        repeat (2) @(posedge mclk);
    endtask

    // Expected status word with the tracker field left out.
    function automatic logic [10:0] stat_of(input logic [5:0] c, input logic [2:0] m);
        logic dp;
        logic [1:0] sf, mf, s, mo;
        dp = m >= 3'h3;
        sf = c[2] ? 2'h2 : 2'h1;
        mf = c[4] ? 2'h2 : 2'h1;
        s = !c[0] ? 2'h0 : !dp ? sf : !c[1] ? 2'h0 : c[5] ? sf - 2'h1 : sf;
        mo = !c[3] ? 2'h0 : (dp && c[5]) ? mf - 2'h1 : mf;
        return {m, 3'h0, (c[0] & ~c[2]) | (c[3] & ~c[4]), mo, s};
    endfunction

    initial begin
        logic [31:0] r;
        logic [10:0] x;
        do_reset();
        apb(1'b1, `LSSMC_ADDR_STAT, 32'hffff);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            cmp("reset value", q, i == 0 ? 32'h1 : 32'h0);
        end
        apb(1'b0, 8'h18, 32'h0);
        cmp("unmapped error", e, 1);
        cmp("unmapped data", q, 0);
        // Every control setting in every power mode.
        for (int v = 0; v < 64; v++) begin
            r = $random(seed);
            apb(1'b1, `LSSMC_ADDR_LCTL, {r[31:6], 6'(v)});
            apb(1'b0, `LSSMC_ADDR_LCTL, 32'h0);
            cmp("lctl", q, v);
            for (int m = 0; m < 6; m++) begin
                pmode <= 3'(m);
                apb(1'b0, `LSSMC_ADDR_STAT, 32'h0);
                x = stat_of(6'(v), 3'(m));
                cmp("stat", q & 32'h71f, x);
                cmp("ports", {wake_slow, mon, sup}, x[4:0]);
            end
        end
        // Settle timing, full performance then normal, seen through the interrupt.
        pmode <= 3'h0;
        apb(1'b1, `LSSMC_ADDR_FLAG, 32'h3c);
        apb(1'b1, `LSSMC_ADDR_MASK, 32'h3c);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `LSSMC_ADDR_LCTL, k ? 32'h01 : 32'h05);
            apb(1'b0, `LSSMC_ADDR_FLAG, 32'h0);
            cmp("settle flag", q[0], 1);
            t = 0;
            while (irq !== 1'b1 && t < FP + 20) begin
                @(posedge mclk);
                t++;
            end
            cmp("settle time", t >= (k ? NORM : FP) - 4 && t <= (k ? NORM : FP) + 1, 1);
            apb(1'b0, `LSSMC_ADDR_FLAG, 32'h0);
            cmp("flag after", q, 32'h4);
            apb(1'b1, `LSSMC_ADDR_FLAG, 32'h4);
            @(posedge mclk);
            cmp("irq cleared", irq, 0);
        end
        // Raising the core level with a fast supervisor and a core that lags.
        apb(1'b1, `LSSMC_ADDR_MASK, 32'h10);
        core_ok <= 1'b0;
        apb(1'b1, `LSSMC_ADDR_LCTL, 32'h05);
        pulses = 0;
        apb(1'b1, `LSSMC_ADDR_LEVEL, 32'h1);
        repeat (FP + 10) @(posedge mclk);
        cmp("core fail reset", pulses, 1);
        apb(1'b0, `LSSMC_ADDR_FLAG, 32'h0);
        cmp("core fail event", q[5], 1);
        apb(1'b1, `LSSMC_ADDR_LCTL, 32'h01);
        core_ok <= 1'b1;
        apb(1'b1, `LSSMC_ADDR_LEVEL, 32'h3);
        repeat (NORM + 10) @(posedge mclk);
        cmp("settled core", pulses, 1);
        cmp("masked irq", irq, 0);
        // Wake hazard: safe setting, window edge, hang, recovery, early entry.
        wait_settled();
        hz(10, 1'b0);
        // A manual high side that keeps a normal supervisor on in deep sleep must not arm the hazard.
        apb(1'b1, `LSSMC_ADDR_HCTL, 32'h03);
        wait_settled();
        hz(10, 1'b0);
        apb(1'b1, `LSSMC_ADDR_HCTL, 32'h01);
        apb(1'b1, `LSSMC_ADDR_LCTL, 32'h05);
        wait_settled();
        hz(`LSSMC_HAZARD_CYC + 10, 1'b0);
        hz(10, 1'b1);
        hz(10, 1'b1);
        cmp("hang irq", irq, 1);
        do_reset();
        cmp("recovered", stuck, 0);
        hz(10, 1'b0);
        apb(1'b1, `LSSMC_ADDR_LCTL, 32'h01);
        hz(5, 1'b1);
        // A normal high-side monitor under automatic control arms the hazard on its own.
        do_reset();
        apb(1'b1, `LSSMC_ADDR_HCTL, 32'h28);
        wait_settled();
        hz(10, 1'b1);
        tally_and_finish();
    end
endmodule
